// *** design/ssc_pkg.sv ***
// Package: constants and types of the serial shift clock generator
package ssc_pkg;
  // Core clock and the four shift clock rates
  localparam int unsigned CORE_CLK_HZ = 40_000_000;
  localparam int unsigned RATE0_HZ    = 75_000;
  localparam int unsigned RATE1_HZ    = 150_000;
  localparam int unsigned RATE2_HZ    = 225_000;
  localparam int unsigned RATE3_HZ    = 450_000;
  localparam int unsigned HALF_W      = 9;
  localparam logic [HALF_W-1:0] HALF0 = HALF_W'(CORE_CLK_HZ / (2 * RATE0_HZ));
  localparam logic [HALF_W-1:0] HALF1 = HALF_W'(CORE_CLK_HZ / (2 * RATE1_HZ));
  localparam logic [HALF_W-1:0] HALF2 = HALF_W'(CORE_CLK_HZ / (2 * RATE2_HZ));
  localparam logic [HALF_W-1:0] HALF3 = HALF_W'(CORE_CLK_HZ / (2 * RATE3_HZ));
  localparam logic [HALF_W-1:0] HALF_ZERO = 9'h000;
  localparam logic [HALF_W-1:0] HALF_ONE  = 9'h001;
  // Longest gap from stretch release to the next edge, rounded down
  localparam int unsigned STRETCH_NS  = 3300;
  localparam logic [HALF_W-1:0] STRETCH_CYC =
    HALF_W'(STRETCH_NS * (CORE_CLK_HZ / 1_000_000) / 1000);
  // Cycles before the synchronised pin reflects our own release
  localparam logic [HALF_W-1:0] SYNC_GUARD = 9'h004;
  // Rate codes
  localparam logic [1:0] RATE_75K  = 2'h0;
  localparam logic [1:0] RATE_150K = 2'h1;
  localparam logic [1:0] RATE_225K = 2'h2;
  localparam logic [1:0] RATE_450K = 2'h3;
  localparam logic [1:0] RATE_RST  = 2'h0;
  // Register indices and byte addresses
  localparam int unsigned CLK_SEL_IDX = 'h39;
  localparam int unsigned CTRL_IDX    = 'h3A;
  localparam int unsigned CMD_IDX     = 'h3B;
  localparam int unsigned STAT_IDX    = 'h3C;
  localparam logic [7:0] CLK_SEL_ADDR = 8'(CLK_SEL_IDX * 4);
  localparam logic [7:0] CTRL_ADDR    = 8'(CTRL_IDX * 4);
  localparam logic [7:0] CMD_ADDR     = 8'(CMD_IDX * 4);
  localparam logic [7:0] STAT_ADDR    = 8'(STAT_IDX * 4);
  // Field positions
  localparam int unsigned RATE_LSB    = 0;
  localparam int unsigned CTRL_MASTER = 0;
  localparam int unsigned CTRL_SIO    = 1;
  localparam int unsigned CTRL_WRQ0   = 2;
  localparam int unsigned CTRL_WRQ1   = 3;
  localparam int unsigned CMD_CANCEL  = 0;
  localparam int unsigned CMD_FORCE   = 1;
  // Clock counter values
  localparam logic [3:0] CNT_ZERO  = 4'h0;
  localparam logic [3:0] CNT_ONE   = 4'h1;
  localparam logic [3:0] CNT_EIGHT = 4'h8;
  localparam logic [3:0] CNT_NINE  = 4'h9;
  // Generator states, Gray along idle-lead-trail
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_LEAD  = 2'b01,
    ST_TRAIL = 2'b11
  } ssc_state_type;
endpackage

// *** design/ssc_top.sv ***
// Shift clock generator of serial interface 1 with APB registers
// Operation
// [R1] Rate field 00/01/10/11 selects 75, 150, 225 or 450 kHz.
// [R2] The generated clock drives the pin only in master mode.
// [R3] Once started the clock runs without a break until a wait.
// [R4] Bus master mode holds the pin low while waiting.
// [R5] Bus forced wait while waiting gives one pulse, nothing counts.
// [R6] Forced wait while running stops at the next pulse's end.
// [R7] Forced wait stops counting, unless issued with the pin low; here it stops when issued in the lead phase, which is low in serial I/O mode.
// [R8] Bus wait cancel while running changes nothing.
// [R9] After a slave stretch ends the next edge comes within 3.3 us.
// [R10] In slave mode the pin is released and takes the outside level.
// [R11] Serial I/O master mode holds the pin high while waiting.
// [R12] Serial I/O forced wait while waiting clears the counter.
// [R13] Serial I/O wait cancel while running clears the counter.
// [R14] Counter counts active pin edges from zero, wraps 9 to 1.
// [R15] Wait request bits stop the clock after count eight or nine.
//
// Implementation choice: the APB register port.
module ssc_top
  import ssc_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        srst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Shift clock pin
  input  wire logic        serial_io_clock_pin_in,
  output logic             serial_io_clock_pin_out,
  output logic             serial_io_clock_pin_oe
);

  logic [1:0]        rate_ff;
  logic              master_select_flag_ff;
  logic              sio_mode_ff;
  logic              wait_request_bit0_ff;
  logic              wait_request_bit1_ff;
  logic              cmd_cancel_ff;
  logic              cmd_force_ff;
  ssc_state_type     st_ff;
  logic [HALF_W-1:0] ph_cnt_ff;
  logic [HALF_W-1:0] half_cyc;
  logic [HALF_W-1:0] ph_lim;
  logic              fw_pend_ff;
  logic              fw_arm_ff;
  logic              cnt_hold_ff;
  logic              single_ff;
  logic              stretch_ff;
  logic [3:0]        cnt_ff;
  logic              pin_meta_ff;
  logic              pin_sync_ff;
  logic              pin_prev_ff;
  logic              pready_ff;
  logic              pslverr_ff;
  logic [31:0]       prdata_ff;
  logic              pin_out_ff;
  logic              pin_oe_ff;
  logic              wr_en;
  logic              rd_take;
  logic              mapped;
  logic [31:0]       rd_mux;
  logic              ph_end;
  logic              hold;
  logic              act_edge;
  logic              cnt_step;
  logic              cnt_clr;
  logic              mode_chg;
  logic              ord_stop;
  logic              lead_stop;
  logic              lvl;

  ////////////////////////////////////////////////////////////////////////
  // APB slave: one wait state, answer registered
  assign rd_take = psel && penable && !pready_ff;
  assign wr_en   = psel && penable && pready_ff && pwrite;
  assign mapped  = (paddr == CLK_SEL_ADDR) || (paddr == CTRL_ADDR) ||
                   (paddr == CMD_ADDR) || (paddr == STAT_ADDR);

  // Read data mux, unused bits read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      CLK_SEL_ADDR: rd_mux[RATE_LSB +: 2] = rate_ff;
      CTRL_ADDR: begin
        rd_mux[CTRL_MASTER] = master_select_flag_ff;
        rd_mux[CTRL_SIO]    = sio_mode_ff;
        rd_mux[CTRL_WRQ0]   = wait_request_bit0_ff;
        rd_mux[CTRL_WRQ1]   = wait_request_bit1_ff;
      end
      STAT_ADDR: rd_mux = {24'h00_0000, cnt_ff, 1'b0,
                           cnt_ff == CNT_NINE, cnt_ff == CNT_EIGHT,
                           st_ff == ST_IDLE};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Ready, error and read data
  always_ff @(posedge core_clk) begin
    if (srst) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end else begin
      pready_ff  <= rd_take;
      pslverr_ff <= rd_take && !mapped;
      if (rd_take) begin
        prdata_ff <= pwrite ? 32'h0000_0000 : rd_mux;
      end
    end
  end

  assign pready  = pready_ff;
  assign pslverr = pslverr_ff;
  assign prdata  = prdata_ff;

  ////////////////////////////////////////////////////////////////////////
  // Clock select: rate only, upper bits fixed at zero
  always_ff @(posedge core_clk) begin
    if (srst) begin
      rate_ff <= RATE_RST;
    end else if (wr_en && paddr == CLK_SEL_ADDR) begin
      rate_ff <= pwdata[RATE_LSB +: 2];
    end
  end

  // Mode and wait request bits
  always_ff @(posedge core_clk) begin
    if (srst) begin
      master_select_flag_ff <= 1'b0;
      sio_mode_ff           <= 1'b0;
      wait_request_bit0_ff  <= 1'b0;
      wait_request_bit1_ff  <= 1'b0;
    end else if (wr_en && paddr == CTRL_ADDR) begin
      master_select_flag_ff <= pwdata[CTRL_MASTER];
      sio_mode_ff           <= pwdata[CTRL_SIO];
      wait_request_bit0_ff  <= pwdata[CTRL_WRQ0];
      wait_request_bit1_ff  <= pwdata[CTRL_WRQ1];
    end
  end

  // Wait control commands, one-cycle pulses
  always_ff @(posedge core_clk) begin
    if (srst) begin
      cmd_cancel_ff <= 1'b0;
      cmd_force_ff  <= 1'b0;
    end else begin
      cmd_cancel_ff <= wr_en && paddr == CMD_ADDR && pwdata[CMD_CANCEL];
      cmd_force_ff  <= wr_en && paddr == CMD_ADDR && pwdata[CMD_FORCE];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Half period in core cycles for the selected rate
  always_comb begin
    unique case (rate_ff)
      RATE_75K:  half_cyc = HALF0; // [R1]
      RATE_150K: half_cyc = HALF1; // [R1]
      RATE_225K: half_cyc = HALF2; // [R1]
      RATE_450K: half_cyc = HALF3; // [R1]
    endcase
  end

  // After a stretch the high phase is cut short to meet the bound
  assign ph_lim = (stretch_ff && STRETCH_CYC < half_cyc) ?
                  STRETCH_CYC : half_cyc; // [R9]
  assign ph_end = ph_cnt_ff >= ph_lim - HALF_ONE;
  assign hold   = st_ff == ST_LEAD && !sio_mode_ff && !pin_sync_ff &&
                  ph_cnt_ff >= SYNC_GUARD; // [R9]

  // Pin synchroniser; only the second stage and its one-cycle copy are looked at
  // Reset to the released level so no false edge follows reset
  always_ff @(posedge core_clk) begin
    if (srst) begin
      pin_meta_ff <= 1'b1;
      pin_sync_ff <= 1'b1;
      pin_prev_ff <= 1'b1;
    end else begin
      pin_meta_ff <= serial_io_clock_pin_in;
      pin_sync_ff <= pin_meta_ff;
      pin_prev_ff <= pin_sync_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Clock counter reads the pin, so it also counts a slave's clock
  assign act_edge = sio_mode_ff ? (pin_prev_ff && !pin_sync_ff) :
                                  (!pin_prev_ff && pin_sync_ff); // [R14]
  assign cnt_step = act_edge && !cnt_hold_ff &&
                    (st_ff != ST_IDLE || !master_select_flag_ff);
  assign mode_chg = wr_en && paddr == CTRL_ADDR &&
                    pwdata[CTRL_SIO] != sio_mode_ff;
  assign cnt_clr  = mode_chg ||
                    (sio_mode_ff && (cmd_cancel_ff || cmd_force_ff));

  // Clear beats a step in the same cycle
  always_ff @(posedge core_clk) begin
    if (srst) begin
      cnt_ff <= CNT_ZERO;
    end else if (cnt_clr) begin
      cnt_ff <= CNT_ZERO; // [R12] [R13]
    end else if (cnt_step) begin
      cnt_ff <= (cnt_ff == CNT_NINE) ? CNT_ONE : cnt_ff + CNT_ONE; // [R14]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Stop at the end of the lead phase, which is the mode's idle edge
  assign ord_stop  = (wait_request_bit0_ff && cnt_ff == CNT_EIGHT) ||
                     (wait_request_bit1_ff && cnt_ff == CNT_NINE); // [R15]
  assign lead_stop = single_ff || ord_stop || (fw_pend_ff && fw_arm_ff);

  // Generator state and phase counter
  always_ff @(posedge core_clk) begin
    if (srst || !master_select_flag_ff) begin
      st_ff     <= ST_IDLE; // [R2]
      ph_cnt_ff <= HALF_ZERO;
    end else begin
      unique case (st_ff)
        ST_IDLE: begin
          // A cancel starts in either mode; a bus force alone gives one pulse
          if (cmd_cancel_ff || (cmd_force_ff && !sio_mode_ff)) begin
            st_ff     <= ST_LEAD; // [R5]
            ph_cnt_ff <= HALF_ZERO;
          end
        end
        ST_LEAD: begin
          if (ph_end && !hold) begin
            st_ff     <= lead_stop ? ST_IDLE : ST_TRAIL; // [R6] [R15]
            ph_cnt_ff <= HALF_ZERO;
          end else if (!hold) begin
            ph_cnt_ff <= ph_cnt_ff + HALF_ONE; // [R9]
          end
        end
        ST_TRAIL: begin
          // A cancel here is ignored: running already
          if (ph_end) begin
            st_ff     <= ST_LEAD; // [R3] [R8]
            ph_cnt_ff <= HALF_ZERO;
          end else begin
            ph_cnt_ff <= ph_cnt_ff + HALF_ONE;
          end
        end
        default: begin
          st_ff     <= ST_IDLE;
          ph_cnt_ff <= HALF_ZERO;
        end
      endcase
    end
  end

  // Forced wait, single pulse and stretch bookkeeping
  always_ff @(posedge core_clk) begin
    if (srst || !master_select_flag_ff) begin
      fw_pend_ff  <= 1'b0;
      fw_arm_ff   <= 1'b0;
      cnt_hold_ff <= 1'b0;
      single_ff   <= 1'b0;
      stretch_ff  <= 1'b0;
    end else if (st_ff == ST_IDLE) begin
      fw_pend_ff  <= 1'b0;
      fw_arm_ff   <= 1'b0;
      stretch_ff  <= 1'b0;
      single_ff   <= cmd_force_ff && !sio_mode_ff && !cmd_cancel_ff;
      cnt_hold_ff <= cmd_force_ff && !sio_mode_ff && !cmd_cancel_ff; // [R5]
    end else begin
      if (cmd_force_ff && !fw_pend_ff) begin
        fw_pend_ff  <= 1'b1;
        fw_arm_ff   <= st_ff == ST_TRAIL || (ph_end && !hold); // [R6]
        cnt_hold_ff <= st_ff == ST_LEAD; // [R7]
      end else if (st_ff == ST_LEAD && ph_end && !hold && fw_pend_ff) begin
        fw_arm_ff   <= 1'b1; // [R6]
      end
      if (st_ff == ST_LEAD && ph_end && !hold) begin
        stretch_ff <= 1'b0;
      end else if (hold) begin
        stretch_ff <= 1'b1; // [R9]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin drive: bus mode is open drain, serial I/O is push-pull
  assign lvl = (st_ff == ST_LEAD) ? !sio_mode_ff : sio_mode_ff;

  always_ff @(posedge core_clk) begin
    if (srst || !master_select_flag_ff) begin
      pin_out_ff <= 1'b0; // [R10]
      pin_oe_ff  <= 1'b0; // [R2] [R10]
    end else if (sio_mode_ff) begin
      pin_out_ff <= lvl; // [R11]
      pin_oe_ff  <= 1'b1;
    end else begin
      pin_out_ff <= 1'b0; // [R4]
      pin_oe_ff  <= !lvl;
    end
  end

  assign serial_io_clock_pin_out = pin_out_ff;
  assign serial_io_clock_pin_oe  = pin_oe_ff;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  localparam int A_RESUME_MAX = 134;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  a_slave_release: assert property ( // [R2]
    !master_select_flag_ff |=> !serial_io_clock_pin_oe)
    else $error("pin driven in slave mode");
  a_bus_idle_low: assert property ( // [R4]
    master_select_flag_ff && !sio_mode_ff && st_ff == ST_IDLE
    |=> serial_io_clock_pin_oe && !serial_io_clock_pin_out)
    else $error("bus idle pin not held low");
  a_sio_idle_high: assert property ( // [R11]
    master_select_flag_ff && sio_mode_ff && st_ff == ST_IDLE
    |=> serial_io_clock_pin_oe && serial_io_clock_pin_out)
    else $error("serial I/O idle pin not high");
  a_trail_length: assert property ( // [R1]
    st_ff == ST_TRAIL && ph_end && ph_cnt_ff < half_cyc
    |-> ph_cnt_ff == half_cyc - HALF_ONE)
    else $error("half period length wrong");
  a_runs_on: assert property ( // [R3]
    st_ff == ST_TRAIL && master_select_flag_ff |=> st_ff != ST_IDLE)
    else $error("clock stopped outside a lead phase");
  a_single_pulse: assert property ( // [R5]
    master_select_flag_ff && !sio_mode_ff && st_ff == ST_IDLE &&
    cmd_force_ff && !cmd_cancel_ff
    |=> st_ff == ST_LEAD && single_ff && cnt_hold_ff)
    else $error("forced wait gave no counted-free pulse");
  a_sio_force_clr: assert property ( // [R12]
    sio_mode_ff && cmd_force_ff && !mode_chg |=> cnt_ff == CNT_ZERO)
    else $error("counter not cleared by forced wait");
  a_sio_cancel_clr: assert property ( // [R13]
    sio_mode_ff && cmd_cancel_ff && st_ff != ST_IDLE
    |=> cnt_ff == CNT_ZERO)
    else $error("counter not cleared by cancel");
  a_count_wrap: assert property ( // [R14]
    cnt_step && !cnt_clr && cnt_ff == CNT_NINE |=> cnt_ff == CNT_ONE)
    else $error("counter did not wrap to one");
  a_stretch_resume: assert property ( // [R9]
    st_ff == ST_LEAD && stretch_ff && pin_sync_ff
    |-> ##[1:A_RESUME_MAX] st_ff != ST_LEAD)
    else $error("no clock edge after stretch release");

endmodule

// *** sim/ssc_partner.sv ***
// Far bus station model on the shift clock line
module ssc_partner (
  // Design side of the pin
  input  wire logic dut_out,
  input  wire logic dut_oe,
  // Level seen on the wire
  output logic      wire_lvl
);
  timeunit 1ns;
  timeprecision 1ps;
  logic pull_low;
  initial pull_low = 1'b0;
  // Wired-and with pull-up, so a released pin floats high
  assign wire_lvl = (dut_oe ? dut_out : 1'b1) & ~pull_low;
  // Hold the line low to ask for a wait, then let go
  task automatic stretch(input int ns);
    #3;
    pull_low = 1'b1;
    #(ns);
    pull_low = 1'b0;
  endtask
  // External clock frame at 200 ns, line idles high outside it
  task automatic burst(input int cnt);
    // Start off the core clock edge, like a truly foreign clock
    #3;
    repeat (cnt) begin
      pull_low = 1'b1;
      #100;
      pull_low = 1'b0;
      #100;
    end
  endtask
endmodule

// *** sim/test_serial_shift_clock_generator.sv ***
// Bench for the serial shift clock generator
module test_serial_shift_clock_generator
  import ssc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk, srst, psel, penable, pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, d;
  logic        pready, pslverr, pin_out, pin_oe, wire_lvl, e, lv;
  int          num_errors = 0;
  int          compares = 0;
  int          len, n;
  int unsigned hz[4] = '{RATE0_HZ, RATE1_HZ, RATE2_HZ, RATE3_HZ};

  ssc_top u_dut (.core_clk(core_clk), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serial_io_clock_pin_in(wire_lvl), .serial_io_clock_pin_out(pin_out),
    .serial_io_clock_pin_oe(pin_oe));
  ssc_partner u_far (.dut_out(pin_out), .dut_oe(pin_oe),
    .wire_lvl(wire_lvl));

  // 40 MHz core clock
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string what);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: %s seen %h exp %h", $time, what, seen,
               exp);
    end
  endtask
  // One APB transfer; result left in d and e
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd);
    int k;
    k = 0;
    @(posedge core_clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    d = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) check(32'h0, 32'h1, "apb hang");
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    apb(1'b1, a, v);
  endtask
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  // Bounded wait for a wire level; n holds the cycles spent
  task automatic wait_lvl(input logic v);
    n = 0;
    while (wire_lvl !== v && n < 3000) begin
      @(posedge core_clk);
      n++;
    end
    if (n == 3000) check(32'h0, 32'h1, "wire stuck");
  endtask
  // Length of the next whole high phase
  task automatic high_len;
    wait_lvl(1'b0);
    wait_lvl(1'b1);
    len = 0;
    while (wire_lvl === 1'b1 && len < 3000) begin
      @(posedge core_clk);
      len++;
    end
  endtask
  // Poll status until the generator waits again
  task automatic wait_idle;
    int k;
    k = 0;
    do begin
      rd(STAT_ADDR);
      k++;
    end while (d[0] !== 1'b1 && k < 400);
    if (d[0] !== 1'b1) check(32'h0, 32'h1, "never idle");
  endtask
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask
  task automatic stop_test;
    $display("compares %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Watchdog, well beyond the expected run
  initial begin
    #1_500_000;
    num_errors++;
    stop_test;
  end

  // Main sequence
  initial begin
    srst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (4) @(posedge core_clk);
    srst <= 1'b0;
    rd(CLK_SEL_ADDR);
    check(d, 32'h0, "rate reset");
    wr(CLK_SEL_ADDR, 32'hF);
    rd(CLK_SEL_ADDR);
    check(d, 32'h3, "rate back");
    rd(8'h00);
    check({31'h0, e}, 32'h1, "unmapped");
    done("registers");
    // Slave: commands ignored, pin stays released under outside clock
    wr(CMD_ADDR, 32'h1);
    u_far.burst(9);
    check({31'h0, pin_oe}, 32'h0, "slave drive");
    done("slave");
    wr(CTRL_ADDR, 32'h1);
    // Mode lands at the completion edge, pin registers one edge later
    repeat (2) @(posedge core_clk);
    check({30'h0, pin_oe, pin_out}, 32'h2, "bus idle");
    for (int r = 0; r < 4; r++) begin
      wr(CLK_SEL_ADDR, 32'(r));
      wr(CMD_ADDR, 32'h1);
      high_len;
      check(32'(len), 32'(CORE_CLK_HZ / (2 * hz[r])), "half");
      high_len;
      check(32'(len), 32'(CORE_CLK_HZ / (2 * hz[r])), "run");
      wr(CMD_ADDR, 32'h2);
      wait_idle;
      check(d & 32'h1, 32'h1, "forced stop");
      check({30'h0, pin_oe, pin_out}, 32'h2, "bus wait");
    end
    done("rates");
    // Wait requests at count eight, nine, then eight past the wrap
    for (int i = 0; i < 3; i++) begin
      wr(CTRL_ADDR, (i == 1) ? 32'h9 : 32'h5);
      wr(CMD_ADDR, 32'h1);
      wait_idle;
      check(d & 32'hF7, (i == 1) ? 32'h95 : 32'h83, "wreq");
    end
    done("wait requests");
    // Forced wait while waiting: one pulse, nothing counted
    wr(CTRL_ADDR, 32'h1);
    wr(CMD_ADDR, 32'h2);
    lv = wire_lvl;
    n = 0;
    repeat (400) begin
      @(posedge core_clk);
      if (wire_lvl === 1'b1 && lv === 1'b0) n++;
      lv = wire_lvl;
    end
    check(32'(n), 32'h1, "one pulse");
    rd(STAT_ADDR);
    check(d & 32'hF1, 32'h81, "held count");
    // Cancel while running leaves the waveform alone
    wr(CMD_ADDR, 32'h1);
    high_len;
    wr(CMD_ADDR, 32'h1);
    high_len;
    check(32'(len), 32'(CORE_CLK_HZ / (2 * RATE3_HZ)), "bus cancel");
    wr(CMD_ADDR, 32'h2);
    wait_idle;
    done("bus waits");
    // Slave stretch longer than a half period at the slowest rate
    wr(CLK_SEL_ADDR, 32'h0);
    wr(CMD_ADDR, 32'h1);
    wait_lvl(1'b0);
    wait_lvl(1'b1);
    u_far.stretch(7500);
    wait_lvl(1'b0);
    check(32'(n <= STRETCH_CYC + 3), 32'h1, "stretch");
    wr(CMD_ADDR, 32'h2);
    wait_idle;
    done("stretch");
    // Serial I/O master
    wr(CLK_SEL_ADDR, 32'h3);
    wr(CTRL_ADDR, 32'h3);
    repeat (2) @(posedge core_clk);
    check({30'h0, pin_oe, pin_out}, 32'h3, "sio idle");
    wr(CMD_ADDR, 32'h1);
    wait_lvl(1'b0);
    wait_lvl(1'b1);
    wr(CMD_ADDR, 32'h1);
    rd(STAT_ADDR);
    check(d & 32'hF0, 32'h0, "sio cancel");
    high_len;
    check(32'(len), 32'(CORE_CLK_HZ / (2 * RATE3_HZ)), "sio run");
    wr(CMD_ADDR, 32'h2);
    wait_idle;
    check({30'h0, pin_oe, pin_out}, 32'h3, "sio wait");
    wr(CMD_ADDR, 32'h2);
    rd(STAT_ADDR);
    check(d & 32'hF1, 32'h1, "sio force");
    done("serial io");
    stop_test;
  end
endmodule
